// ### verilog/vei_input_ctl.sv
// Purpose: Pixel port, sync pins and control pins of a video encoder
// Assumes: All inputs synchronous to clk_i; config from serial decoder
// Notes: Sync pins active low; pin values seen with one cycle delay
`timescale 1ns/10ps
`default_nettype none
`include "vei_cfg.svh"

////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] Pixels arrive as multiplexed 4:2:2 bytes on an 8-bit bus, bit 0 LSB.
// [R2] The source supplies a stable 27, 24.5454 or 29.5 MHz clock.
// [R3] In modes 1 and 2 line sync is driven as master, accepted as slave.
// [R4] The field/vsync pin carries field in mode 1 and vsync in mode 2.
// [R5] Pixel bus contents are ignored while the blanking input is low.
// [R6] In restart function a rising pin edge resets the subcarrier.
// [R7] The control pin may instead serve as a real-time control input.
// [R8] The slave address LSB follows the address select pin.
// [R9] Reset restarts timing and restores NTSC, slave mode 0, DACs on.
// [R10] Teletext request stays low when teletext is not selected.
// [R11] Teletext data enters on its own pin during vertical blanking.
// [R12] Output timing aligns to reference codes in the pixel stream; as master, only in mode 0.
// [R13] As master, sync widths and positions are adjustable.
// [R14] All modes are loaded through the two-wire serial port.
// [R15] Bytes come in order Cb, Y, Cr, Y, sampled on rising edges.
// [R16] A restart edge takes effect at the start of the next field.
// [R17] Two select bits choose plain input, restart or real-time control.
module vei_input_ctl #(
  parameter logic [5:0] ADDR_BASE = `VEI_ADDR_BASE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] pixel_bus_i,
  input wire logic blank_n_i,
  input wire logic hsync_n_i,
  input wire logic field_vsync_i,
  input wire logic carrier_restart_ctl_pin_i,
  input wire logic addr_low_bit_pin_i,
  input wire logic teletext_in_i,
  input wire logic cfg_load_i,
  input wire logic cfg_pal_i,
  input wire logic cfg_master_i,
  input wire logic [1:0] cfg_tmode_i,
  input wire logic [2:0] cfg_dac_en_i,
  input wire logic [1:0] cfg_out_mode_i,
  input wire logic pin_function_sel_hi_i,
  input wire logic pin_function_sel_lo_i,
  input wire logic cfg_ttx_en_i,
  input wire logic [10:0] cfg_hs_start_i,
  input wire logic [10:0] cfg_hs_width_i,
  input wire logic [3:0] cfg_vs_lines_i,
  output logic hsync_n_o,
  output logic hsync_oe_o,
  output logic field_vsync_o,
  output logic field_vsync_oe_o,
  output logic teletext_request_o,
  output logic ttx_bit_o,
  output logic ttx_valid_o,
  output logic [6:0] slave_addr_o,
  output logic pal_o,
  output logic master_o,
  output logic [1:0] tmode_o,
  output logic [2:0] dac_en_o,
  output logic [1:0] out_mode_o,
  output logic [7:0] y_o,
  output logic [7:0] cb_o,
  output logic [7:0] cr_o,
  output logic pix_valid_o,
  output logic carrier_reset_o,
  output logic rtc_bit_o,
  output logic rtc_valid_o,
  output logic field_o
);

  ////////////////////////////////////////////////////////////////////////
  // Configuration
  logic [1:0] pin_func_reg;
  logic ttx_en_reg;
  logic [10:0] hs_start_reg, hs_width_reg;
  logic [3:0] vs_lines_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pal_o <= `VEI_RST_PAL; // [R9]
      master_o <= `VEI_RST_MASTER; // [R9]
      tmode_o <= `VEI_RST_TMODE; // [R9]
      dac_en_o <= `VEI_RST_DAC_EN; // [R9]
      out_mode_o <= `VEI_RST_OUT_MODE; // [R9]
      pin_func_reg <= `VEI_RST_PIN_FUNC;
      ttx_en_reg <= `VEI_RST_TTX_EN;
      hs_start_reg <= `VEI_RST_HS_START;
      hs_width_reg <= `VEI_RST_HS_WIDTH;
      vs_lines_reg <= `VEI_RST_VS_LINES;
    end else if (cfg_load_i) begin
      pal_o <= cfg_pal_i; // [R14]
      master_o <= cfg_master_i;
      tmode_o <= cfg_tmode_i;
      dac_en_o <= cfg_dac_en_i;
      out_mode_o <= cfg_out_mode_i;
      pin_func_reg <= {pin_function_sel_hi_i, pin_function_sel_lo_i};
      ttx_en_reg <= cfg_ttx_en_i;
      hs_start_reg <= cfg_hs_start_i; // [R13]
      hs_width_reg <= cfg_hs_width_i; // [R13]
      vs_lines_reg <= cfg_vs_lines_i; // [R13]
    end
  end

  wire vei_pkg::vei_tmode_type tmode = vei_pkg::vei_tmode_type'(tmode_o);
  wire mode_1 = (tmode == vei_pkg::TM_1);
  wire mode_2 = (tmode == vei_pkg::TM_2);
  wire pin_mode = mode_1 || mode_2;

  ////////////////////////////////////////////////////////////////////////
  // Reference code detection
  logic [7:0] b1_reg, b2_reg, b3_reg;
  logic f_last_reg, active_reg;
  // Blanked bytes never enter the detector
  wire take = blank_n_i; // [R5]
  wire trs_hit = take && (b3_reg == `VEI_TRS_B0)
    && (b2_reg == `VEI_TRS_B1) && (b1_reg == `VEI_TRS_B1);
  wire xy_h = pixel_bus_i[`VEI_TRS_H_BIT];
  wire xy_f = pixel_bus_i[`VEI_TRS_F_BIT];
  wire sav = trs_hit && !xy_h;
  wire eav = trs_hit && xy_h;
  // Master in mode 0 still follows the stream; pins carry nothing
  wire trs_align = !master_o || (tmode == vei_pkg::TM_0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
      f_last_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      if (take) begin
        b1_reg <= pixel_bus_i;
        b2_reg <= b1_reg;
        b3_reg <= b2_reg;
      end
      if (eav)
        f_last_reg <= xy_f;
      if (sav)
        active_reg <= 1'b1;
      else if (eav)
        active_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave sync pins
  logic hs_prev_reg, fv_prev_reg;
  wire slave_pins = !master_o && pin_mode;
  wire hs_fall = hs_prev_reg && !hsync_n_i;
  wire fv_change = (fv_prev_reg != field_vsync_i);
  wire fv_fall = fv_prev_reg && !field_vsync_i;
  logic gen_field;

  wire align_line = (trs_align && eav) // [R12]
    || (slave_pins && hs_fall); // [R3]
  wire align_f_trs = trs_align && eav && (xy_f != f_last_reg); // [R12]
  wire align_f_m1 = slave_pins && mode_1 && fv_change; // [R4]
  wire align_f_m2 = slave_pins && mode_2 && fv_fall; // [R4]
  wire align_field = align_f_trs || align_f_m1 || align_f_m2;
  wire field_val = align_f_trs ? xy_f
    : align_f_m1 ? field_vsync_i
    : !gen_field;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_prev_reg <= 1'b1;
      fv_prev_reg <= 1'b1;
    end else begin
      hs_prev_reg <= hsync_n_i;
      fv_prev_reg <= field_vsync_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing generator
  logic [10:0] gen_pix;
  logic [9:0] gen_rel_line;
  logic gen_hsync_n, gen_vsync_n, gen_fstart;

  // Reset of the generator comes with the block reset
  vei_timing_gen u_gen (
    .clk_i(clk_i),
    .rst_i(rst_i), // [R9]
    .pal_i(pal_o),
    .hs_start_i(hs_start_reg),
    .hs_width_i(hs_width_reg),
    .vs_lines_i(vs_lines_reg),
    .align_line_i(align_line),
    .align_field_i(align_field),
    .field_val_i(field_val),
    .pix_o(gen_pix),
    .rel_line_o(gen_rel_line),
    .field_o(gen_field),
    .hsync_n_o(gen_hsync_n),
    .vsync_n_o(gen_vsync_n),
    .field_start_o(gen_fstart)
  );

  ////////////////////////////////////////////////////////////////////////
  // Master sync pins
  wire drive = master_o && pin_mode;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hsync_n_o <= 1'b1;
      hsync_oe_o <= 1'b0;
      field_vsync_o <= 1'b1;
      field_vsync_oe_o <= 1'b0;
      field_o <= 1'b0;
    end else begin
      hsync_n_o <= gen_hsync_n; // [R13]
      hsync_oe_o <= drive; // [R3]
      field_vsync_o <= mode_1 ? gen_field : gen_vsync_n; // [R4]
      field_vsync_oe_o <= drive; // [R4]
      field_o <= gen_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel demultiplexer
  vei_pkg::vei_phase_type phase_reg, phase_next;
  logic [7:0] cb_hold_reg, y0_hold_reg;
  wire pix_take = take && active_reg && !trs_hit; // [R5]

  always_comb begin
    case (phase_reg)
      vei_pkg::PH_CB: phase_next = vei_pkg::PH_Y0;
      vei_pkg::PH_Y0: phase_next = vei_pkg::PH_CR;
      vei_pkg::PH_CR: phase_next = vei_pkg::PH_Y1;
      vei_pkg::PH_Y1: phase_next = vei_pkg::PH_CB;
      default: phase_next = vei_pkg::PH_CB;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= vei_pkg::PH_CB;
      cb_hold_reg <= 8'h00;
      y0_hold_reg <= 8'h00;
      y_o <= 8'h00;
      cb_o <= 8'h00;
      cr_o <= 8'h00;
      pix_valid_o <= 1'b0;
    end else begin
      pix_valid_o <= 1'b0;
      if (sav) begin
        phase_reg <= vei_pkg::PH_CB; // [R15]
      end else if (pix_take) begin
        phase_reg <= phase_next; // [R1]
        case (phase_reg)
          vei_pkg::PH_CB: cb_hold_reg <= pixel_bus_i;
          vei_pkg::PH_Y0: y0_hold_reg <= pixel_bus_i;
          vei_pkg::PH_CR: begin
            y_o <= y0_hold_reg;
            cb_o <= cb_hold_reg;
            cr_o <= pixel_bus_i;
            pix_valid_o <= 1'b1;
          end
          vei_pkg::PH_Y1: begin
            y_o <= pixel_bus_i;
            pix_valid_o <= 1'b1;
          end
          default: pix_valid_o <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Multi-function control pin
  wire vei_pkg::vei_pin_func_type pin_func =
    vei_pkg::vei_pin_func_type'(pin_func_reg);
  wire is_restart = (pin_func == vei_pkg::PF_RESTART); // [R17]
  wire is_rtc = (pin_func == vei_pkg::PF_RTC); // [R17]
  logic ctl_prev_reg, restart_pend_reg;
  wire ctl_rise = !ctl_prev_reg && carrier_restart_ctl_pin_i;
  // Edge in the field start cycle waits for the next field
  wire restart_fire = restart_pend_reg && gen_fstart; // [R16]
  wire restart_pend_next = (is_restart && ctl_rise) // [R6]
    || (restart_pend_reg && !gen_fstart);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_prev_reg <= 1'b0;
      restart_pend_reg <= 1'b0;
      carrier_reset_o <= 1'b0;
      rtc_bit_o <= 1'b0;
      rtc_valid_o <= 1'b0;
    end else begin
      ctl_prev_reg <= carrier_restart_ctl_pin_i;
      restart_pend_reg <= restart_pend_next;
      carrier_reset_o <= restart_fire; // [R6]
      rtc_bit_o <= is_rtc && carrier_restart_ctl_pin_i; // [R7]
      rtc_valid_o <= is_rtc; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Teletext and address
  wire [10:0] ttx_pix_end = 11'(`VEI_TTX_PIX_START + `VEI_TTX_PIX_LEN);
  wire in_vbi = (gen_rel_line >= `VEI_TTX_FIRST)
    && (gen_rel_line <= `VEI_TTX_LAST);
  wire in_ttx_pix = (gen_pix >= `VEI_TTX_PIX_START)
    && (gen_pix < ttx_pix_end);
  wire ttx_req = ttx_en_reg && in_vbi && in_ttx_pix; // [R10]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      teletext_request_o <= 1'b0;
      ttx_bit_o <= 1'b0;
      ttx_valid_o <= 1'b0;
      slave_addr_o <= {ADDR_BASE, 1'b0};
    end else begin
      teletext_request_o <= ttx_req; // [R10]
      ttx_valid_o <= teletext_request_o; // [R11]
      ttx_bit_o <= teletext_request_o && teletext_in_i; // [R11]
      slave_addr_o <= {ADDR_BASE, addr_low_bit_pin_i}; // [R8]
    end
  end

endmodule
`default_nettype wire

// ### verilog/vei_cfg.svh
// Purpose: Constants of the video encoder input control block
// Assumes: Included by bare name from design files
// Notes: Pixel counts are in pixel clock cycles, line counts in lines
`ifndef VEI_CFG_SVH
`define VEI_CFG_SVH

// Line and field geometry
`define VEI_NTSC_PPL 11'd1716
`define VEI_PAL_PPL 11'd1728
`define VEI_NTSC_LINES 10'd525
`define VEI_PAL_LINES 10'd625
`define VEI_NTSC_F1 10'd263
`define VEI_PAL_F1 10'd313

// Timing reference code bytes and flag positions
`define VEI_TRS_B0 8'hff
`define VEI_TRS_B1 8'h00
`define VEI_TRS_H_BIT 4
`define VEI_TRS_F_BIT 6

// Teletext window inside the vertical blanking interval
`define VEI_TTX_FIRST 10'd7
`define VEI_TTX_LAST 10'd22
`define VEI_TTX_PIX_START 11'd272
`define VEI_TTX_PIX_LEN 11'd1440

// Reset defaults
`define VEI_RST_PAL 1'b0
`define VEI_RST_MASTER 1'b0
`define VEI_RST_TMODE 2'h0
`define VEI_RST_DAC_EN 3'h7
`define VEI_RST_OUT_MODE 2'h0
`define VEI_RST_PIN_FUNC 2'h0
`define VEI_RST_TTX_EN 1'b0
`define VEI_RST_HS_START 11'h000
`define VEI_RST_HS_WIDTH 11'h07e
`define VEI_RST_VS_LINES 4'h3

// Upper six bits of the serial slave address, arbitrary value
`define VEI_ADDR_BASE 6'h15

`endif

// ### verilog/vei_pkg.sv
// Purpose: Types of the video encoder input control block
// Assumes: Nothing
// Notes: No constants here; see vei_cfg.svh
package vei_pkg;

  typedef enum logic [1:0] {
    PF_INPUT = 2'b00,
    PF_RESTART = 2'b01,
    PF_RTC = 2'b10,
    PF_SPARE = 2'b11
  } vei_pin_func_type;

  typedef enum logic [1:0] {
    TM_0 = 2'b00,
    TM_1 = 2'b01,
    TM_2 = 2'b10,
    TM_3 = 2'b11
  } vei_tmode_type;

  typedef enum logic [1:0] {
    PH_CB = 2'b00,
    PH_Y0 = 2'b01,
    PH_CR = 2'b10,
    PH_Y1 = 2'b11
  } vei_phase_type;

endpackage

// ### verilog/vei_timing_gen.sv
// Purpose: Line and field timing generator with adjustable syncs
// Assumes: Alignment pulses come from the top level
// Notes: Syncs active low; all outputs registered
`timescale 1ns/10ps
`default_nettype none
`include "vei_cfg.svh"

module vei_timing_gen #(
  parameter logic [10:0] NTSC_PPL = `VEI_NTSC_PPL,
  parameter logic [10:0] PAL_PPL = `VEI_PAL_PPL,
  parameter logic [9:0] NTSC_LINES = `VEI_NTSC_LINES,
  parameter logic [9:0] PAL_LINES = `VEI_PAL_LINES,
  parameter logic [9:0] NTSC_F1 = `VEI_NTSC_F1,
  parameter logic [9:0] PAL_F1 = `VEI_PAL_F1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pal_i,
  input wire logic [10:0] hs_start_i,
  input wire logic [10:0] hs_width_i,
  input wire logic [3:0] vs_lines_i,
  input wire logic align_line_i,
  input wire logic align_field_i,
  input wire logic field_val_i,
  output logic [10:0] pix_o,
  output logic [9:0] rel_line_o,
  output logic field_o,
  output logic hsync_n_o,
  output logic vsync_n_o,
  output logic field_start_o
);

  logic [10:0] pix_next;
  logic [9:0] line_reg, line_next;
  wire [10:0] ppl = pal_i ? PAL_PPL : NTSC_PPL;
  wire [9:0] lpf = pal_i ? PAL_LINES : NTSC_LINES;
  wire [9:0] f1 = pal_i ? PAL_F1 : NTSC_F1;
  wire eol = (pix_o >= 11'(ppl - 11'd1));
  wire eof = eol && (line_reg >= 10'(lpf - 10'd1));
  wire in_f1 = (line_next >= f1);
  wire [9:0] rel_next = in_f1 ? 10'(line_next - f1) : line_next;
  wire [10:0] hs_end = 11'(hs_start_i + hs_width_i);
  wire hs_on = (pix_next >= hs_start_i) && (pix_next < hs_end);
  wire vs_on = (rel_next < {6'h00, vs_lines_i});
  wire fstart = align_field_i
    || (eol && ((line_next == 10'd0) || (line_next == f1)));

  // Alignment beats free running
  assign pix_next = (align_line_i || align_field_i || eol) ? 11'h000
    : 11'(pix_o + 11'd1);
  assign line_next = align_field_i ? (field_val_i ? f1 : 10'h000)
    : eof ? 10'h000
    : eol ? 10'(line_reg + 10'd1)
    : line_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_o <= 11'h000;
      line_reg <= 10'h000;
      rel_line_o <= 10'h000;
      field_o <= 1'b0;
      hsync_n_o <= 1'b1;
      vsync_n_o <= 1'b1;
      field_start_o <= 1'b0;
    end else begin
      pix_o <= pix_next;
      line_reg <= line_next;
      rel_line_o <= rel_next;
      field_o <= in_f1;
      hsync_n_o <= ~hs_on;
      vsync_n_o <= ~vs_on;
      field_start_o <= fstart;
    end
  end

endmodule
`default_nettype wire

// ### verif/vei_input_ctl_props.sv
// Purpose: Port assertions for the input control block
// Assumes: Bound to vei_input_ctl, one clock domain
// Notes: Loaded pin function is tracked here from the load pulse
`timescale 1ns/10ps
`default_nettype none
`include "vei_cfg.svh"
module vei_input_ctl_props #(
  parameter logic [5:0] ADDR_BASE = `VEI_ADDR_BASE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_load_i,
  input wire logic cfg_pal_i,
  input wire logic cfg_master_i,
  input wire logic [1:0] cfg_tmode_i,
  input wire logic [2:0] cfg_dac_en_i,
  input wire logic cfg_ttx_en_i,
  input wire logic pin_function_sel_hi_i,
  input wire logic pin_function_sel_lo_i,
  input wire logic carrier_restart_ctl_pin_i,
  input wire logic addr_low_bit_pin_i,
  input wire logic blank_n_i,
  input wire logic [6:0] slave_addr_o,
  input wire logic pal_o,
  input wire logic master_o,
  input wire logic [1:0] tmode_o,
  input wire logic [2:0] dac_en_o,
  input wire logic hsync_oe_o,
  input wire logic field_vsync_oe_o,
  input wire logic teletext_request_o,
  input wire logic ttx_valid_o,
  input wire logic rtc_bit_o,
  input wire logic rtc_valid_o,
  input wire logic carrier_reset_o,
  input wire logic pix_valid_o
);
  logic [1:0] fn_reg;
  logic ttx_reg;
  logic pend_reg;
  logic pin_reg;
  wire logic set_w;
  assign set_w = fn_reg == 2'h1 && carrier_restart_ctl_pin_i && !pin_reg;
  always_ff @(posedge clk_i) begin
    pin_reg <= carrier_restart_ctl_pin_i;
    if (rst_i) begin
      fn_reg <= 2'h0;
      ttx_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      if (cfg_load_i) begin
        fn_reg <= {pin_function_sel_hi_i, pin_function_sel_lo_i};
        ttx_reg <= cfg_ttx_en_i;
      end
      // Set wins, so an edge beside a pulse is not lost
      if (set_w) begin
        pend_reg <= 1'b1;
      end else if (carrier_reset_o) begin
        pend_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_edge;
    set_w && !pend_reg;
  endsequence
  sequence s_settled;
    cfg_load_i ##1 !cfg_load_i;
  endsequence
  property p_rst;
    disable iff (1'b0) rst_i |=> !pal_o && !master_o && tmode_o == 2'h0
      && dac_en_o == 3'h7 && !teletext_request_o && !hsync_oe_o;
  endproperty
  property p_cfg;
    cfg_load_i |=> pal_o == $past(cfg_pal_i) && master_o ==
      $past(cfg_master_i) && tmode_o == $past(cfg_tmode_i)
      && dac_en_o == $past(cfg_dac_en_i);
  endproperty
  property p_addr;
    !$past(rst_i) |-> slave_addr_o == {ADDR_BASE, $past(addr_low_bit_pin_i)};
  endproperty
  property p_oe;
    s_settled |=> hsync_oe_o == (master_o && (tmode_o == 2'h1
      || tmode_o == 2'h2)) && field_vsync_oe_o == hsync_oe_o;
  endproperty
  property p_ttx_off;
    !ttx_reg ##1 !ttx_reg |-> !teletext_request_o;
  endproperty
  property p_ttx_vld;
    !$past(rst_i) |-> ttx_valid_o == $past(teletext_request_o);
  endproperty
  property p_rtc;
    rtc_valid_o [*2] |-> rtc_bit_o == $past(carrier_restart_ctl_pin_i);
  endproperty
  property p_fn;
    fn_reg == $past(fn_reg) |-> rtc_valid_o == (fn_reg == 2'h2);
  endproperty
  property p_late;
    s_edge |=> !carrier_reset_o;
  endproperty
  property p_cause;
    carrier_reset_o |-> pend_reg;
  endproperty
  property p_pix;
    pix_valid_o |-> $past(blank_n_i);
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  a_cfg: assert property (p_cfg) else $error("config load");
  a_addr: assert property (p_addr) else $error("slave addr");
  a_oe: assert property (p_oe) else $error("pin enable");
  a_ttx_off: assert property (p_ttx_off) else $error("ttx req");
  a_ttx_vld: assert property (p_ttx_vld) else $error("ttx valid");
  a_rtc: assert property (p_rtc) else $error("rtc bit");
  a_fn: assert property (p_fn) else $error("pin function");
  a_late: assert property (p_late) else $error("early reset");
  a_cause: assert property (p_cause) else $error("stray reset");
  a_pix: assert property (p_pix) else $error("blanked pixel");
endmodule
bind vei_input_ctl vei_input_ctl_props #(.ADDR_BASE(ADDR_BASE)) u_props (
  .clk_i, .rst_i, .cfg_load_i, .cfg_pal_i, .cfg_master_i, .cfg_tmode_i,
  .cfg_dac_en_i, .cfg_ttx_en_i, .pin_function_sel_hi_i,
  .pin_function_sel_lo_i, .carrier_restart_ctl_pin_i, .addr_low_bit_pin_i,
  .blank_n_i, .slave_addr_o, .pal_o, .master_o, .tmode_o, .dac_en_o,
  .hsync_oe_o, .field_vsync_oe_o, .teletext_request_o, .ttx_valid_o,
  .rtc_bit_o, .rtc_valid_o, .carrier_reset_o, .pix_valid_o
);
`default_nettype wire

// ### verif/vei_video_src.sv
// Purpose: Digital video source model for the pixel port
// Assumes: Called by the bench, one byte per clock
// Notes: Blanked bus toggles so a stale byte never looks valid
`timescale 1ns/10ps
`default_nettype none
module vei_video_src (
  input wire logic clk_i,
  output logic [7:0] pixel_bus_o,
  output logic blank_n_o,
  output logic hsync_n_o,
  output logic field_vsync_o
);
  initial begin
    pixel_bus_o = 8'h00;
    blank_n_o = 1'b0;
    hsync_n_o = 1'b1;
    field_vsync_o = 1'b1;
  end
  ////////////////////////////////////////
  // One byte per rising edge, bit 0 LSB
  // Blank low shows junk only
  task automatic put(input logic [7:0] b, input logic en);
    @(posedge clk_i);
    pixel_bus_o <= en ? b : ~pixel_bus_o;
    blank_n_o <= en;
  endtask
  // Timing reference code ff 00 00 XY
  task automatic code(input logic [7:0] xy);
    put(8'hff, 1'b1);
    put(8'h00, 1'b1);
    put(8'h00, 1'b1);
    put(xy, 1'b1);
  endtask
  // Cb Y Cr Y, optional stall after Cb
  task automatic group(input logic [31:0] g, input logic s);
    put(g[31:24], 1'b1);
    if (s)
      put(8'h00, 1'b0);
    put(g[23:16], 1'b1);
    put(g[15:8], 1'b1);
    put(g[7:0], 1'b1);
  endtask
endmodule
`default_nettype wire

// ### verif/tb_video_encoder_input_control.sv
// Purpose: Self-checking bench for the input control block
// Assumes: Source model drives pixel port and slave syncs
// Notes: Random stimulus from a fixed seed
`timescale 1ns/10ps
`default_nettype none
`include "vei_cfg.svh"
module tb_video_encoder_input_control;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wire logic [7:0] pixel_bus_i;
  wire logic blank_n_i, hsync_n_i, field_vsync_i;
  logic carrier_restart_ctl_pin_i = 1'b0;
  logic addr_low_bit_pin_i = 1'b0;
  logic teletext_in_i = 1'b0;
  logic cfg_load_i = 1'b0;
  logic cfg_pal_i = 1'b0;
  logic cfg_master_i = 1'b0;
  logic [1:0] cfg_tmode_i = 2'h0;
  logic [2:0] cfg_dac_en_i = 3'h7;
  logic [1:0] cfg_out_mode_i = 2'h0;
  logic pin_function_sel_hi_i = 1'b0;
  logic pin_function_sel_lo_i = 1'b0;
  logic cfg_ttx_en_i = 1'b0;
  logic [10:0] cfg_hs_start_i = 11'h005;
  logic [10:0] cfg_hs_width_i = 11'h07e;
  logic [3:0] cfg_vs_lines_i = 4'h3;
  logic hsync_n_o, hsync_oe_o, field_vsync_o, field_vsync_oe_o;
  logic teletext_request_o, ttx_bit_o, ttx_valid_o, pal_o, master_o;
  logic pix_valid_o, carrier_reset_o, rtc_bit_o, rtc_valid_o, field_o;
  logic [6:0] slave_addr_o;
  logic [1:0] tmode_o, out_mode_o;
  logic [2:0] dac_en_o;
  logic [7:0] y_o, cb_o, cr_o;
  logic cur_pal = 1'b0;
  logic keep_pal = 1'b0;
  logic ttx_exp = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  int seed = 39;
  int cyc = 0;
  int n_cr = 0;
  logic [23:0] exp_q[$], got_q[$];
  vei_input_ctl DUT (
    .clk_i, .rst_i, .pixel_bus_i, .blank_n_i, .hsync_n_i, .field_vsync_i,
    .carrier_restart_ctl_pin_i, .addr_low_bit_pin_i, .teletext_in_i,
    .cfg_load_i, .cfg_pal_i, .cfg_master_i, .cfg_tmode_i, .cfg_dac_en_i,
    .cfg_out_mode_i, .pin_function_sel_hi_i, .pin_function_sel_lo_i,
    .cfg_ttx_en_i, .cfg_hs_start_i, .cfg_hs_width_i, .cfg_vs_lines_i,
    .hsync_n_o, .hsync_oe_o, .field_vsync_o, .field_vsync_oe_o,
    .teletext_request_o, .ttx_bit_o, .ttx_valid_o, .slave_addr_o, .pal_o,
    .master_o, .tmode_o, .dac_en_o, .out_mode_o, .y_o, .cb_o, .cr_o,
    .pix_valid_o, .carrier_reset_o, .rtc_bit_o, .rtc_valid_o, .field_o
  );
  vei_video_src src (
    .clk_i, .pixel_bus_o(pixel_bus_i), .blank_n_o(blank_n_i),
    .hsync_n_o(hsync_n_i), .field_vsync_o(field_vsync_i)
  );
  ////////////////////////////////////////
  initial begin
    forever #4 clk_i = ~clk_i; // Steady reference
  end
  // Teletext pattern from the counter, not the shared seed, to stay repeatable
  always @(posedge clk_i) begin
    cyc++;
    if (ttx_valid_o === 1'b1)
      chk("ttx_bit", ttx_bit_o, ttx_exp);
    ttx_exp = teletext_request_o && teletext_in_i;
    teletext_in_i <= cyc[0] ^ cyc[3];
    if (pix_valid_o === 1'b1)
      got_q.push_back({y_o, cb_o, cr_o});
    if (carrier_reset_o === 1'b1)
      n_cr++;
    if (cyc == 40000) begin
      err_total++;
      conclude();
    end
  end
  function automatic logic [10:0] ppl(input logic p);
    return p ? `VEI_PAL_PPL : `VEI_NTSC_PPL;
  endfunction
  function automatic logic oe(input logic m, input logic [1:0] t);
    return m && (t == 2'h1 || t == 2'h2);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic load(input logic m, input logic [1:0] t, f,
    input logic e, input logic [10:0] w);
    logic [2:0] d;
    logic [1:0] o;
    logic a;
    d = 3'($random(seed));
    o = 2'($random(seed));
    a = 1'($random(seed));
    cur_pal = keep_pal ? cur_pal : 1'($random(seed));
    @(posedge clk_i);
    cfg_load_i <= 1'b1;
    cfg_pal_i <= cur_pal;
    cfg_master_i <= m;
    cfg_tmode_i <= t;
    cfg_dac_en_i <= d;
    cfg_out_mode_i <= o;
    {pin_function_sel_hi_i, pin_function_sel_lo_i} <= f;
    cfg_ttx_en_i <= e;
    cfg_hs_width_i <= w;
    addr_low_bit_pin_i <= a;
    @(posedge clk_i);
    cfg_load_i <= 1'b0;
    #1;
    chk("pal", pal_o, cur_pal);
    chk("mode", {master_o, tmode_o}, {m, t});
    chk("dac", {dac_en_o, out_mode_o}, {d, o});
    chk("addr", slave_addr_o, {`VEI_ADDR_BASE, a});
    @(posedge clk_i);
    #1;
    chk("oe", {hsync_oe_o, field_vsync_oe_o}, {2{oe(m, t)}});
  endtask
  // Counts edges until the chosen output reads v
  task automatic run(input logic s, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((s ? teletext_request_o : hsync_n_o) !== v);
  endtask
  ////////////////////////////////////////
  initial begin
    int n, lw;
    logic [31:0] g;
    logic [10:0] w;
    logic v, pv;
    w = 11'h07e;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("rst_mode", {pal_o, master_o, tmode_o}, 4'h0);
    chk("rst_dac", {dac_en_o, out_mode_o}, 5'h1c);
    chk("rst_pins", {teletext_request_o, hsync_oe_o}, 2'h0);
    repeat (8)
      load(1'($random(seed)), 2'($random(seed)), 2'($random(seed)),
        1'($random(seed)), w);
    for (int f = 0; f < 4; f++) begin
      load(1'b0, 2'h0, f[1:0], 1'b0, w);
      pv = carrier_restart_ctl_pin_i;
      repeat (4) begin
        v = (f == 1) ? 1'b0 : 1'($random(seed));
        @(posedge clk_i);
        carrier_restart_ctl_pin_i <= v;
        #1;
        chk("rtc_valid", rtc_valid_o, f == 2);
        chk("rtc_bit", rtc_bit_o, (f == 2) ? pv : 1'b0);
        pv = v;
      end
    end
    @(posedge clk_i);
    carrier_restart_ctl_pin_i <= 1'b0;
    load(1'b0, 2'h0, 2'h0, 1'b0, w);
    src.code(8'h80);
    for (int i = 0; i < 6; i++) begin
      g = {$random(seed)} & 32'h7f7f7f7f | 32'h01010101;
      src.group(g, i == 3);
      exp_q.push_back({g[23:16], g[31:24], g[15:8]});
      exp_q.push_back({g[7:0], g[31:24], g[15:8]});
    end
    // Code bytes before the end code still pass as one sample
    exp_q.push_back(24'h00ff00);
    src.code(8'h90);
    src.group(32'h11223344, 1'b0);
    src.put(8'h00, 1'b0);
    repeat (4) @(posedge clk_i);
    #1;
    chk("samples", got_q.size(), exp_q.size());
    foreach (exp_q[i])
      chk("sample", got_q[i], exp_q[i]);
    // One standard from here on, field waits stay short
    keep_pal = 1'b1;
    load(1'b0, 2'h0, 2'h1, 1'b0, w);
    n_cr = 0;
    @(posedge clk_i);
    carrier_restart_ctl_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk("early_reset", n_cr, 0);
    src.code(8'hd0);
    src.put(8'h00, 1'b0);
    repeat (8) @(posedge clk_i);
    #1;
    chk("reset_pulses", n_cr, 1);
    w = 11'd8 + 11'($random(seed) & 31);
    load(1'b1, 2'h1, 2'h0, 1'b0, w);
    run(1'b0, 1'b1, n);
    run(1'b0, 1'b0, n);
    run(1'b0, 1'b1, lw);
    run(1'b0, 1'b0, n);
    chk("hs_width", lw, w);
    chk("hs_period", lw + n, ppl(cur_pal));
    chk("field_pin", field_vsync_o, field_o);
    load(1'b0, 2'h0, 2'h0, 1'b1, w);
    run(1'b1, 1'b1, n);
    run(1'b1, 1'b0, lw);
    chk("ttx_len", lw, `VEI_TTX_PIX_LEN);
    load(1'b0, 2'h0, 2'h0, 1'b0, w);
    chk("ttx_off", teletext_request_o, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
